// File: include/rxagc_regs.svh
// register offsets, field positions and reset values of the receive configuration bank
`ifndef RXAGC_REGS_SVH
`define RXAGC_REGS_SVH
`define RXAGC_ADDR_W 8
`define RXAGC_OFS_AGC_CFG0 8'h33
`define RXAGC_OFS_AGC_CFG1 8'h34
`define RXAGC_OFS_AGC_THR 8'h35
`define RXAGC_OFS_DIGRX 8'h36
`define RXAGC_OFS_PEAK_DLY 8'h37
`define RXAGC_OFS_STATUS 8'h38
`define RXAGC_RST_AGC_CFG0 8'h2b
`define RXAGC_RST_AGC_CFG1 8'h03
`define RXAGC_RST_AGC_THR 8'h08
`define RXAGC_RST_DIGRX 8'h40
`define RXAGC_RST_PEAK_DLY 8'h00
`define RXAGC_RST_RESTART 1'h0
`define RXAGC_MASK_AGC_CFG0 8'h7f
`define RXAGC_MASK_AGC_CFG1 8'h03
`define RXAGC_MASK_RESTART 8'h20
`define RXAGC_GAIN_AUTO 2'h3
`define RXAGC_DGC_RESERVED 3'h6
`define RXAGC_LATENCY_BITS 4'h2
`define RXAGC_UPPER_BASE 10'h100
`define RXAGC_STEP 10'h010
`endif

// File: include/rxagc_pkg.sv
// types of the receive configuration bank
package rxagc_pkg;
   typedef enum logic [1:0] {
      RXAGC_MANCH = 2'b00,
      RXAGC_DIFF_MANCH = 2'b01,
      RXAGC_BIPH_SPACE = 2'b10,
      RXAGC_BIPH_MARK = 2'b11
   } rxagc_code_type;
   typedef enum logic [1:0] {
      RXAGC_IDLE = 2'b00,
      RXAGC_WAIT = 2'b01,
      RXAGC_CAPT = 2'b10
   } rxagc_peak_type;
   typedef struct packed {
      logic [7:0] cfg0_reg;
      logic [1:0] cfg1_reg;
      logic [7:0] thr_reg;
      logic [7:0] digrx_reg;
      logic [7:0] dly_reg;
      logic restart_reg;
      logic [7:0] rdata_reg;
      rxagc_peak_type peak_reg;
      logic [8:0] bitcnt_reg;
      logic peak_go_reg;
      logic rx_init_reg;
      logic fr_init_reg;
      logic agc_rst_reg;
      logic chip_reg;
      logic data_reg;
      logic mf_reg;
      logic gain_auto_reg;
      logic [10:0] upper_reg;
      logic [9:0] lower_reg;
      logic [7:0] hyst_reg;
      logic [7:0] dgc_reg;
      logic dgc_err_reg;
   } rxagc_state_type;
endpackage : rxagc_pkg

// File: rtl/rxagc_bank.sv
// receive agc and digital baseband configuration bank with derived controls
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "rxagc_regs.svh"

// Summary of operation
// [R1] gain correction 14.5 dB plus half-dB steps
// [R2] hysteresis 12.8 to 25.6 dB, reset two
// [R3] gain 0/-15/-30 dB or automatic, reset automatic
// [R4] threshold offset 25.5 to 63.9 dB, reset three
// [R5] upper threshold offset plus 25.6 plus 1.6*step
// [R6] lower threshold offset plus 1.6*step, reset eight
// [R7] receiver reinit on end or sync loss
// [R8] framer reinit at cycle start, run slave
// [R9] no framer reinit keeps wakeup data usable
// [R10] line code selects four decoder variants
// [R11] chip invert on output and decoder input
// [R12] external invert on data and filter output
// [R13] bypass routes rssi around anti-alias filter
// [R14] corner 40 kHz clear, 80 kHz set
// [R15] peak capture delayed bits after frame sync
// [R16] fixed latency added to peak start
// [R17] unused bits read zero, code six reserved
// [R18] agc restart in polling start, hold exit
module rxagc_bank
   import rxagc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic end_of_message_i,
   input wire logic sync_loss_i,
   input wire logic cycle_start_i,
   input wire logic run_mode_slave_i,
   input wire logic self_polling_mode_i,
   input wire logic config_start_i,
   input wire logic hold_exit_i,
   input wire logic frame_sync_i,
   input wire logic bit_strobe_i,
   input wire logic chip_raw_i,
   input wire logic data_raw_i,
   input wire logic mf_raw_i,
   output logic [1:0] frontend_gain_select_o,
   output logic gain_auto_o,
   output logic [1:0] threshold_hysteresis_sel_o,
   output logic [7:0] hysteresis_db_x10_o,
   output logic [2:0] rssi_gain_correction_o,
   output logic [7:0] rssi_gain_half_db_o,
   output logic gain_correction_reserved_o,
   output logic [10:0] upper_threshold_x10_o,
   output logic [9:0] lower_threshold_x10_o,
   output logic rx_reinit_o,
   output logic framer_reinit_o,
   output logic agc_restart_o,
   output logic [1:0] line_code_o,
   output logic chip_data_out_o,
   output logic decoder_chip_o,
   output logic data_out_o,
   output logic matched_filter_data_out_o,
   output logic antialias_bypass_o,
   output logic antialias_corner_select_o,
   output logic rssi_peak_capture_o
);

   rxagc_state_type s_reg;
   rxagc_state_type s_next;

   // threshold offset in tenths of a dB
   function automatic logic [9:0] offset_x10(input logic [1:0] sel);
      case (sel)
         2'h0: offset_x10 = 10'd255;
         2'h1: offset_x10 = 10'd383;
         2'h2: offset_x10 = 10'd511;
         default: offset_x10 = 10'd639;
      endcase
   endfunction : offset_x10

   function automatic logic [9:0] step_x10(input logic [3:0] n);
      step_x10 = {2'b00, n, 4'h0};
   endfunction : step_x10

   // programmed bit delay plus fixed pipeline latency
   function automatic logic [8:0] peak_start(input logic [7:0] dly);
      peak_start = {1'b0, dly} + {5'h00, `RXAGC_LATENCY_BITS};
   endfunction : peak_start

   always_comb begin
      s_next = s_reg;
      s_next.rdata_reg = 8'h00;
      if (wr_i) begin
         case (addr_i)
            `RXAGC_OFS_AGC_CFG0: s_next.cfg0_reg = wdata_i & `RXAGC_MASK_AGC_CFG0; // R17
            `RXAGC_OFS_AGC_CFG1: begin
               s_next.cfg1_reg = wdata_i[1:0]; // R4
               s_next.restart_reg = wdata_i[5];
            end
            `RXAGC_OFS_AGC_THR: s_next.thr_reg = wdata_i;
            `RXAGC_OFS_DIGRX: s_next.digrx_reg = wdata_i;
            `RXAGC_OFS_PEAK_DLY: s_next.dly_reg = wdata_i;
            default: begin
            end
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            `RXAGC_OFS_AGC_CFG0: s_next.rdata_reg = s_reg.cfg0_reg;
            `RXAGC_OFS_AGC_CFG1: s_next.rdata_reg = {2'h0, s_reg.restart_reg, 3'h0, s_reg.cfg1_reg}; // R17
            `RXAGC_OFS_AGC_THR: s_next.rdata_reg = s_reg.thr_reg;
            `RXAGC_OFS_DIGRX: s_next.rdata_reg = s_reg.digrx_reg;
            `RXAGC_OFS_PEAK_DLY: s_next.rdata_reg = s_reg.dly_reg;
            `RXAGC_OFS_STATUS: s_next.rdata_reg = {5'h0, s_reg.dgc_err_reg, s_reg.peak_reg};
            default: s_next.rdata_reg = 8'h00;
         endcase
      end
      // derived agc figures
      s_next.dgc_reg = 8'd29 + {5'h0, s_reg.cfg0_reg[6:4]}; // R1
      s_next.gain_auto_reg = (s_reg.cfg0_reg[1:0] == `RXAGC_GAIN_AUTO); // R3
      s_next.dgc_err_reg = (s_reg.cfg0_reg[6:4] == `RXAGC_DGC_RESERVED); // R17
      case (s_reg.cfg0_reg[3:2])
         2'h0: s_next.hyst_reg = 8'd128; // R2
         2'h1: s_next.hyst_reg = 8'd171;
         2'h2: s_next.hyst_reg = 8'd213;
         default: s_next.hyst_reg = 8'hff; // 25.6 dB saturates at 255
      endcase
      s_next.upper_reg = {1'b0, offset_x10(s_reg.cfg1_reg)} + {1'b0, `RXAGC_UPPER_BASE}
                         + {1'b0, step_x10(s_reg.thr_reg[7:4])}; // R5
      s_next.lower_reg = offset_x10(s_reg.cfg1_reg) + step_x10(s_reg.thr_reg[3:0]); // R6
      // reinit and restart pulses
      s_next.rx_init_reg = s_reg.digrx_reg[7] & (end_of_message_i | sync_loss_i); // R7
      s_next.fr_init_reg = s_reg.digrx_reg[6] & cycle_start_i & run_mode_slave_i; // R8 R9
      s_next.agc_rst_reg = s_reg.restart_reg & ((self_polling_mode_i & config_start_i)
                           | (run_mode_slave_i & hold_exit_i)); // R18
      // data path inversions
      s_next.chip_reg = chip_raw_i ^ s_reg.digrx_reg[3]; // R11
      s_next.data_reg = data_raw_i ^ s_reg.digrx_reg[2]; // R12
      s_next.mf_reg = mf_raw_i ^ s_reg.digrx_reg[2]; // R12
      // peak capture start counter
      s_next.peak_go_reg = 1'b0;
      case (s_reg.peak_reg)
         RXAGC_IDLE: begin
            if (frame_sync_i) begin
               s_next.bitcnt_reg = peak_start(s_reg.dly_reg); // R15 R16
               s_next.peak_reg = RXAGC_WAIT;
            end
         end
         RXAGC_WAIT: begin
            if (s_reg.rx_init_reg) begin
               s_next.peak_reg = RXAGC_IDLE;
            end else if (frame_sync_i) begin
               // new frame restarts the count
               s_next.bitcnt_reg = peak_start(s_reg.dly_reg); // R15
            end else if (bit_strobe_i) begin
               if (s_reg.bitcnt_reg == 9'h000) begin
                  s_next.peak_go_reg = 1'b1; // R15
                  s_next.peak_reg = RXAGC_CAPT;
               end else begin
                  s_next.bitcnt_reg = s_reg.bitcnt_reg - 9'h001;
               end
            end
         end
         RXAGC_CAPT: begin
            if (s_reg.rx_init_reg) begin
               s_next.peak_reg = RXAGC_IDLE; // R7
            end else if (frame_sync_i) begin
               // re-arm for the next frame
               s_next.bitcnt_reg = peak_start(s_reg.dly_reg); // R15 R16
               s_next.peak_reg = RXAGC_WAIT;
            end
         end
         default: s_next.peak_reg = RXAGC_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_reg <= '0;
         s_reg.cfg0_reg <= `RXAGC_RST_AGC_CFG0; // R2 R3
         s_reg.cfg1_reg <= 2'h3; // R4
         s_reg.thr_reg <= `RXAGC_RST_AGC_THR; // R6
         s_reg.digrx_reg <= `RXAGC_RST_DIGRX; // R8 R14
         s_reg.dly_reg <= `RXAGC_RST_PEAK_DLY;
         s_reg.restart_reg <= `RXAGC_RST_RESTART;
         s_reg.peak_reg <= RXAGC_IDLE;
         s_reg.dgc_reg <= 8'd31;
         s_reg.gain_auto_reg <= 1'b1;
         s_reg.hyst_reg <= 8'd213;
         s_reg.upper_reg <= 11'd895;
         s_reg.lower_reg <= 10'd767;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata_o = s_reg.rdata_reg;
   assign frontend_gain_select_o = s_reg.cfg0_reg[1:0]; // R3
   assign gain_auto_o = s_reg.gain_auto_reg;
   assign threshold_hysteresis_sel_o = s_reg.cfg0_reg[3:2];
   assign hysteresis_db_x10_o = s_reg.hyst_reg;
   assign rssi_gain_correction_o = s_reg.cfg0_reg[6:4];
   assign rssi_gain_half_db_o = s_reg.dgc_reg;
   assign gain_correction_reserved_o = s_reg.dgc_err_reg;
   assign upper_threshold_x10_o = s_reg.upper_reg;
   assign lower_threshold_x10_o = s_reg.lower_reg;
   assign rx_reinit_o = s_reg.rx_init_reg;
   assign framer_reinit_o = s_reg.fr_init_reg;
   assign agc_restart_o = s_reg.agc_rst_reg;
   assign line_code_o = s_reg.digrx_reg[5:4]; // R10
   assign chip_data_out_o = s_reg.chip_reg;
   assign decoder_chip_o = s_reg.chip_reg; // R11
   assign data_out_o = s_reg.data_reg;
   assign matched_filter_data_out_o = s_reg.mf_reg;
   assign antialias_bypass_o = s_reg.digrx_reg[1]; // R13
   assign antialias_corner_select_o = s_reg.digrx_reg[0]; // R14
   assign rssi_peak_capture_o = s_reg.peak_go_reg;

   sequence seq_cfg0_write;
      wr_i && addr_i == `RXAGC_OFS_AGC_CFG0;
   endsequence
   sequence seq_cfg0_read;
      rd_i && addr_i == `RXAGC_OFS_AGC_CFG0 && !wr_i;
   endsequence
   sequence seq_peak_due;
      s_reg.peak_reg == RXAGC_WAIT && !s_reg.rx_init_reg && !frame_sync_i && bit_strobe_i && s_reg.bitcnt_reg == 9'h000;
   endsequence

   a_write_readback: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R17
      seq_cfg0_write ##1 seq_cfg0_read |=> rdata_o == ($past(wdata_i, 2) & `RXAGC_MASK_AGC_CFG0))
      else $error("cfg0 readback mismatch");
   a_rx_reinit: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R7
      rx_reinit_o == $past(s_reg.digrx_reg[7] & (end_of_message_i | sync_loss_i)))
      else $error("receiver reinit wrong");
   a_framer_reinit: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R8
      framer_reinit_o |-> $past(s_reg.digrx_reg[6] & cycle_start_i & run_mode_slave_i))
      else $error("framer reinit wrong");
   a_agc_restart: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R18
      agc_restart_o |-> $past(s_reg.restart_reg))
      else $error("agc restart without enable");
   a_chip_invert: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R11
      chip_data_out_o == ($past(chip_raw_i) ^ $past(s_reg.digrx_reg[3])))
      else $error("chip inversion wrong");
   a_data_invert: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
      matched_filter_data_out_o == ($past(mf_raw_i) ^ $past(s_reg.digrx_reg[2])))
      else $error("filter data inversion wrong");
   a_upper_above: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
      ##1 upper_threshold_x10_o >= 11'd511)
      else $error("upper threshold too low");
   a_peak_wait: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R15
      rssi_peak_capture_o |-> $past(s_reg.peak_reg) == RXAGC_WAIT)
      else $error("peak capture outside wait");

   a_gain_write: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R3
      (wr_i && addr_i == `RXAGC_OFS_AGC_CFG0) |=> frontend_gain_select_o == $past(wdata_i[1:0]))
      else $error("gain select not written");
   a_hyst_write: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
      (wr_i && addr_i == `RXAGC_OFS_AGC_CFG0) |=> threshold_hysteresis_sel_o == $past(wdata_i[3:2]))
      else $error("hysteresis select not written");
   a_dgc_write: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R1
      (wr_i && addr_i == `RXAGC_OFS_AGC_CFG0) |=> rssi_gain_correction_o == $past(wdata_i[6:4]))
      else $error("gain correction not written");
   a_code_write: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R10
      (wr_i && addr_i == `RXAGC_OFS_DIGRX) |=> line_code_o == $past(wdata_i[5:4]))
      else $error("line code not written");
   a_bypass_write: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R13
      (wr_i && addr_i == `RXAGC_OFS_DIGRX) |=> antialias_bypass_o == $past(wdata_i[1]))
      else $error("bypass not written");
   a_corner_write: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R14
      (wr_i && addr_i == `RXAGC_OFS_DIGRX) |=> antialias_corner_select_o == $past(wdata_i[0]))
      else $error("corner select not written");
   a_gain_auto: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R3
      gain_auto_o == ($past(frontend_gain_select_o) == `RXAGC_GAIN_AUTO))
      else $error("automatic gain flag wrong");
   a_hyst_code0: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
      $past(threshold_hysteresis_sel_o) == 2'h0 |-> hysteresis_db_x10_o == 8'd128)
      else $error("hysteresis code 0 wrong");
   a_hyst_code1: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
      $past(threshold_hysteresis_sel_o) == 2'h1 |-> hysteresis_db_x10_o == 8'd171)
      else $error("hysteresis code 1 wrong");
   a_hyst_code2: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
      $past(threshold_hysteresis_sel_o) == 2'h2 |-> hysteresis_db_x10_o == 8'd213)
      else $error("hysteresis code 2 wrong");
   a_hyst_code3: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
      $past(threshold_hysteresis_sel_o) == 2'h3 |-> hysteresis_db_x10_o == 8'd255)
      else $error("hysteresis code 3 wrong");
   a_dgc_value: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R1
      rssi_gain_half_db_o == 8'd29 + {5'h00, $past(rssi_gain_correction_o)})
      else $error("gain correction value wrong");
   a_dgc_reserved: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R17
      gain_correction_reserved_o == ($past(rssi_gain_correction_o) == `RXAGC_DGC_RESERVED))
      else $error("reserved code flag wrong");
   a_upper_value: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
      upper_threshold_x10_o == {1'b0, offset_x10($past(s_reg.cfg1_reg))} + 11'd256 + {3'h0, $past(s_reg.thr_reg[7:4]), 4'h0})
      else $error("upper threshold value wrong");
   a_lower_value: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R6
      lower_threshold_x10_o == offset_x10($past(s_reg.cfg1_reg)) + {2'h0, $past(s_reg.thr_reg[3:0]), 4'h0})
      else $error("lower threshold value wrong");
   a_data_out_inv: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
      data_out_o == ($past(data_raw_i) ^ $past(s_reg.digrx_reg[2])))
      else $error("data inversion wrong");
   a_decoder_chip: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R11
      decoder_chip_o == ($past(chip_raw_i) ^ $past(s_reg.digrx_reg[3])))
      else $error("decoder chip inversion wrong");
   a_rx_reinit_off: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R7
      !s_reg.digrx_reg[7] |=> !rx_reinit_o)
      else $error("receiver reinit while disabled");
   a_framer_keep: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
      !s_reg.digrx_reg[6] |=> !framer_reinit_o)
      else $error("framer reinit while disabled");
   a_framer_fire: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R8
      (s_reg.digrx_reg[6] && cycle_start_i && run_mode_slave_i) |=> framer_reinit_o)
      else $error("framer reinit missing");
   a_restart_poll: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R18
      (s_reg.restart_reg && self_polling_mode_i && config_start_i) |=> agc_restart_o)
      else $error("agc restart missing at config start");
   a_restart_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R18
      (s_reg.restart_reg && run_mode_slave_i && hold_exit_i) |=> agc_restart_o)
      else $error("agc restart missing at hold exit");
   a_cfg1_unused: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R17
      (rd_i && addr_i == `RXAGC_OFS_AGC_CFG1) |=> rdata_o[7:6] == 2'h0 && rdata_o[4:2] == 3'h0)
      else $error("unused cfg1 bits not zero");
   a_unmapped_read: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R17
      (rd_i && (addr_i < `RXAGC_OFS_AGC_CFG0 || addr_i > `RXAGC_OFS_STATUS)) |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_idle: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R17
      !rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read cycle");
   a_status_read: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R17
      (rd_i && addr_i == `RXAGC_OFS_STATUS) |=> rdata_o == {5'h00, $past(gain_correction_reserved_o), $past(s_reg.peak_reg)})
      else $error("status read wrong");
   a_peak_single: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R15
      rssi_peak_capture_o |=> !rssi_peak_capture_o)
      else $error("peak capture longer than one cycle");
   a_peak_due: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R15
      seq_peak_due |=> rssi_peak_capture_o)
      else $error("peak capture missing");
   a_peak_state: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R15
      rssi_peak_capture_o |-> s_reg.peak_reg == RXAGC_CAPT)
      else $error("capture without capture state");
   a_peak_load: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R16
      (frame_sync_i && !(s_reg.rx_init_reg && s_reg.peak_reg != RXAGC_IDLE))
      |=> s_reg.peak_reg == RXAGC_WAIT && s_reg.bitcnt_reg == {1'b0, $past(s_reg.dly_reg)} + 9'd2)
      else $error("peak delay not loaded");
   a_peak_reinit: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R7
      (s_reg.rx_init_reg && s_reg.peak_reg != RXAGC_IDLE) |=> s_reg.peak_reg == RXAGC_IDLE)
      else $error("peak detector not reinitialised");
endmodule : rxagc_bank

// File: tb/rxagc_frontend.sv
// behavioural front end model: frame sync then a burst of bit strobes
`timescale 1ns/1ps
module rxagc_frontend (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   output logic frame_sync_o,
   output logic bit_strobe_o
);
   logic [6:0] cnt_reg;
   logic act_reg;
   // strobes only inside a frame, every fourth cycle
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         act_reg <= 1'b0;
         cnt_reg <= 7'h00;
         frame_sync_o <= 1'b0;
         bit_strobe_o <= 1'b0;
      end else begin
         frame_sync_o <= start_i;
         bit_strobe_o <= act_reg && (cnt_reg[1:0] == 2'h3);
         if (start_i) begin
            act_reg <= 1'b1;
            cnt_reg <= 7'h00;
         end else if (act_reg) begin
            cnt_reg <= cnt_reg + 7'h01;
            if (cnt_reg == 7'h3f) act_reg <= 1'b0;
         end
      end
   end
endmodule : rxagc_frontend

// File: tb/test_rxagc_bank.sv
// self-checking bench of the receive configuration bank
`timescale 1ns/1ps
module test_rxagc_bank;
   import rxagc_pkg::*;
   logic clock_i = 1'b0, rst_b_i = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, rms = 1'b0, self_polling_mode = 1'b0;
   logic chip = 1'b0, dat = 1'b0, mf = 1'b0, fs, bs;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [4:0] ev = 5'h00;
   logic [1:0] gsel, hsel, lcode;
   logic [7:0] hdb, gdb;
   logic [2:0] gcor;
   logic [9:0] lo, n = 10'h000, cap_n = 10'h000;
   logic [10:0] up;
   logic gauto, gres, rxi, fri, agr, cho, dco, dto, mfo, byp, cor, cap;
   int fail_count = 0, comparisons = 0;
   always #2.5 clock_i = ~clock_i;
   rxagc_frontend i_fe (.clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(go), .frame_sync_o(fs), .bit_strobe_o(bs));
   rxagc_bank i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .end_of_message_i(ev[4]), .sync_loss_i(ev[3]), .cycle_start_i(ev[2]),
      .run_mode_slave_i(rms), .self_polling_mode_i(self_polling_mode), .config_start_i(ev[1]), .hold_exit_i(ev[0]),
      .frame_sync_i(fs), .bit_strobe_i(bs), .chip_raw_i(chip), .data_raw_i(dat), .mf_raw_i(mf),
      .frontend_gain_select_o(gsel), .gain_auto_o(gauto), .threshold_hysteresis_sel_o(hsel),
      .hysteresis_db_x10_o(hdb), .rssi_gain_correction_o(gcor), .rssi_gain_half_db_o(gdb),
      .gain_correction_reserved_o(gres), .upper_threshold_x10_o(up), .lower_threshold_x10_o(lo),
      .rx_reinit_o(rxi), .framer_reinit_o(fri), .agc_restart_o(agr), .line_code_o(lcode),
      .chip_data_out_o(cho), .decoder_chip_o(dco), .data_out_o(dto), .matched_filter_data_out_o(mfo),
      .antialias_bypass_o(byp), .antialias_corner_select_o(cor), .rssi_peak_capture_o(cap));
   // bits counted from frame sync, latched when capture fires
   always @(posedge clock_i) begin
      if (fs) n <= 10'h000;
      else if (bs) n <= n + 10'h001;
      if (fs) cap_n <= 10'h000;
      else if (cap) cap_n <= n;
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task chk(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task chk_thr(input logic [10:0] got, input logic [10:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk_thr
   // write then read with no gap
   task wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1;
      chk({2'b00, rdata}, {2'b00, e});
   endtask : wrrd
   task wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
      @(posedge clock_i);
      #1;
   endtask : wrr
   task rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1;
      chk({2'b00, rdata}, {2'b00, e});
   endtask : rdc
   task evt(input logic [4:0] e, input logic [2:0] exp);
      @(posedge clock_i);
      ev <= e;
      @(posedge clock_i);
      ev <= 5'h00;
      #1;
      chk({7'h00, rxi, fri, agr}, {7'h00, exp});
   endtask : evt
   task peak(input logic [7:0] d);
      wrr(8'h37, d);
      @(posedge clock_i);
      go <= 1'b1;
      @(posedge clock_i);
      go <= 1'b0;
      repeat (90) @(posedge clock_i);
      #1;
      chk(cap_n, {2'b00, d} + 10'h003);
   endtask : peak
   initial begin
      #200000;
      fail_count++;
      end_of_test();
   end
   initial begin
      logic [9:0] offs [4];
      logic [7:0] hy [4];
      logic [3:0] s;
      offs = '{10'h0ff, 10'h17f, 10'h1ff, 10'h27f};
      hy = '{8'h80, 8'hab, 8'hd5, 8'hff};
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      rdc(8'h33, 8'h2b);
      rdc(8'h34, 8'h03);
      rdc(8'h35, 8'h08);
      rdc(8'h36, 8'h40);
      rdc(8'h37, 8'h00);
      rdc(8'h40, 8'h00);
      wrrd(8'h33, 8'hff, 8'h7f);
      for (int i = 0; i < 8; i++) begin
         wrr(8'h33, {1'b0, i[2:0], i[1:0], i[1:0]});
         chk({2'b00, gdb}, 10'(i + 29));
         chk({9'h000, gres}, {9'h000, i == 6});
         chk({2'b00, hdb}, {2'b00, hy[i[1:0]]});
         chk({6'h00, gsel, gauto, gcor == i[2:0]}, {6'h00, i[1:0], i[1:0] == 2'h3, 1'b1});
      end
      $display("test gain done");
      for (int j = 0; j < 4; j++) begin
         s = 4'(j * 5);
         wrr(8'h34, 8'(j));
         wrr(8'h35, {s, ~s});
         chk_thr(up, {1'b0, offs[j]} + 11'h100 + {3'b000, s, 4'h0});
         chk(lo, offs[j] + {2'b00, ~s, 4'h0});
      end
      $display("test threshold done");
      for (int k = 0; k < 4; k++) begin
         @(posedge clock_i);
         chip <= k[0];
         dat <= k[1];
         mf <= ~k[1];
         wrr(8'h36, {2'b00, k[1:0], k[1:0], k[1:0]});
         chk({8'h00, lcode}, 10'(k));
         chk({8'h00, cho, dco}, {8'h00, {2{k[0] ^ k[1]}}});
         chk({8'h00, dto, mfo}, {8'h00, k[1] ^ k[0], ~k[1] ^ k[0]});
         chk({8'h00, byp, cor}, {8'h00, k[1], k[0]});
      end
      $display("test baseband done");
      @(posedge clock_i);
      rms <= 1'b1;
      self_polling_mode <= 1'b1;
      wrr(8'h36, 8'hc0);
      evt(5'h10, 3'h4);
      evt(5'h08, 3'h4);
      evt(5'h04, 3'h2);
      wrr(8'h34, 8'hff);
      rdc(8'h34, 8'h23);
      evt(5'h02, 3'h1);
      evt(5'h01, 3'h1);
      wrr(8'h36, 8'h00);
      wrr(8'h34, 8'h03);
      evt(5'h1f, 3'h0);
      $display("test reinit done");
      peak(8'h03);
      peak(8'h00);
      rdc(8'h38, 8'h02);
      $display("test peak done");
      end_of_test();
   end
endmodule : test_rxagc_bank
